//--- design/mailbox_pkg.sv
// Shared constants and carrier types of the sensor command mailbox.
// Assumes a byte-wide register port driven by an I2C slave on its own clock.
package mailbox_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] THR_HIGH_ADDR  = 8'h16; // Third threshold high.
  localparam logic [7:0] PARAM_ADDR     = 8'h17; // Parameter mailbox.
  localparam logic [7:0] COMMAND_ADDR   = 8'h18; // Command mailbox.
  localparam logic [7:0] RESPONSE_ADDR  = 8'h20; // Command response.
  localparam logic [7:0] FLAGS_ADDR     = 8'h21; // Interrupt flags.

  // ----------------------------------------------------------------------
  // Reset values, fields and codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] THR_HIGH_RST   = 8'h00; // Threshold reset value.
  localparam logic [7:0] PARAM_RST      = 8'h00; // Mailbox reset value.
  localparam logic [7:0] COMMAND_RST    = 8'h00; // Command reset value.
  localparam logic [7:0] RESPONSE_RST   = 8'h00; // Response reset value.
  localparam logic [5:0] FLAGS_RST      = 6'h00; // Flags reset value.
  localparam int         ERR_BIT        = 7;     // Error marker bit.
  localparam int         CMD_DONE_BIT   = 5;     // Command-done flag.
  localparam int         THIRD_BIT      = 4;     // Third proximity flag.
  localparam int         SECOND_BIT     = 3;     // Second proximity flag.
  localparam int         FIRST_BIT      = 2;     // First proximity flag.
  localparam logic [7:0] INVALID_CODE   = 8'h80; // Invalid command.
  localparam logic [7:0] OVF_SECOND     = 8'h89; // Second channel overflow.
  localparam logic [7:0] NOP_CMD        = 8'h00; // No-operation command.
  localparam logic [7:0] RESET_CMD      = 8'h01; // Reset command.

  // A register access carried across the clock crossing as one word.
  typedef struct packed {
    logic       write; // High for a write, low for a read.
    logic [7:0] addr;  // Register offset.
    logic [7:0] data;  // Write data.
  } reg_access_t;

endpackage

//--- design/sensor_host_command_mailbox.sv
// Host-facing command mailbox, threshold and flag logic of the sensor.
// Assumes the I2C slave presents accesses on link_clk and holds one at a time;
// the measurement sequencer sits on core_clk.
module sensor_host_command_mailbox (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        link_clk,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata_q,
  output logic             reg_ack_q,
  output logic             reg_busy_q,
  input  wire logic [7:0]  thr_low,
  input  wire logic        prox3_valid,
  input  wire logic [15:0] prox3_result,
  input  wire logic        prox1_event,
  input  wire logic        prox2_event,
  input  wire logic [1:0]  als_event,
  input  wire logic        seq_done,
  input  wire logic        seq_invalid,
  input  wire logic        seq_ovf_second,
  input  wire logic        seq_sleep,
  input  wire logic        seq_auto_clear,
  input  wire logic        clear_policy,
  input  wire logic [5:0]  irq_enable,
  output logic             cmd_valid_q,
  output logic      [7:0]  cmd_code_q,
  output logic      [7:0]  param_q,
  output logic             awake_q,
  output logic             int_n_q
);

  // ----------------------------------------------------------------------
  // Link side: capture one access and hand it over by toggle
  // ----------------------------------------------------------------------
  mailbox_pkg::reg_access_t req_q;      // Access held stable while busy.
  logic                     req_tgl_q;  // Flips once per new access.
  logic                     rsp_s1_q;   // Answer toggle, first stage.
  logic                     rsp_s2_q;   // Answer toggle, second stage.
  logic                     rsp_s3_q;   // Answer toggle, previous value.
  logic                     rsp_tgl_q;  // Core answer toggle.
  logic              [7:0]  rsp_data_q; // Core answer data, stable on flip.

  // The word is held until answered, so the core reads it settled.
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_q      <= '0;
      req_tgl_q  <= 1'b0;
      reg_busy_q <= 1'b0;
    end else if (!reg_busy_q && (reg_we || reg_re)) begin
      req_q      <= '{write: reg_we, addr: reg_addr, data: reg_wdata};
      req_tgl_q  <= ~req_tgl_q;
      reg_busy_q <= 1'b1;
    end else if (rsp_s3_q != rsp_s2_q) begin
      reg_busy_q <= 1'b0;
    end
  end

  // The answer toggle passes two flops before the change is detected.
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_s1_q <= 1'b0;
      rsp_s2_q <= 1'b0;
      rsp_s3_q <= 1'b0;
    end else begin
      rsp_s1_q <= rsp_tgl_q;
      rsp_s2_q <= rsp_s1_q;
      rsp_s3_q <= rsp_s2_q;
    end
  end

  // Completion pulse and read data back to the slave.
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_ack_q   <= 1'b0;
      reg_rdata_q <= 8'h00;
    end else begin
      reg_ack_q <= (rsp_s3_q != rsp_s2_q);
      if (rsp_s3_q != rsp_s2_q) begin
        reg_rdata_q <= rsp_data_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Core side: receive the access
  // ----------------------------------------------------------------------
  logic       req_s1_q;    // Request toggle, first stage.
  logic       req_s2_q;    // Request toggle, second stage.
  logic       req_s3_q;    // Request toggle, previous value.
  logic       take;        // One core cycle per access.
  logic       wr;          // Taken access is a write.
  logic [7:0] thr_high_q;  // Third threshold high byte.
  logic [7:0] command_q;   // Last command written.
  logic [7:0] response_q;  // Response code or counter.
  logic [5:0] flags_q;     // Interrupt flags, bits 5:0.
  logic       cmd_wr;      // Command write taken this cycle.
  logic       cmd_clear;   // Command is reset or no-op.
  logic       err_held;    // An error code is held.

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  assign take      = req_s3_q != req_s2_q;
  assign wr        = take && req_q.write;
  assign cmd_wr    = wr && (req_q.addr == mailbox_pkg::COMMAND_ADDR);
  assign cmd_clear = (req_q.data == mailbox_pkg::NOP_CMD) ||
                     (req_q.data == mailbox_pkg::RESET_CMD);
  assign err_held  = response_q[mailbox_pkg::ERR_BIT];

  // Read decode; reserved flag bits and unmapped offsets read zero.
  function automatic logic [7:0] read_reg(input logic [7:0] a);
    case (a)
      mailbox_pkg::THR_HIGH_ADDR: read_reg = thr_high_q;
      mailbox_pkg::PARAM_ADDR:    read_reg = param_q;
      mailbox_pkg::COMMAND_ADDR:  read_reg = command_q;
      mailbox_pkg::RESPONSE_ADDR: read_reg = response_q;
      mailbox_pkg::FLAGS_ADDR:    read_reg = {2'b00, flags_q};
      default:                    read_reg = 8'h00;
    endcase
  endfunction

  // Answer every access; the host sees completion, not a fixed delay.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_tgl_q  <= 1'b0;
      rsp_data_q <= 8'h00;
    end else if (take) begin
      rsp_tgl_q  <= ~rsp_tgl_q;
      rsp_data_q <= read_reg(req_q.addr);
    end
  end

  // ----------------------------------------------------------------------
  // Plain storage registers
  // ----------------------------------------------------------------------
  // Only the high byte lives here, so a compare between the two byte
  // writes sees the new high byte with the old low one.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      thr_high_q <= mailbox_pkg::THR_HIGH_RST;
      param_q    <= mailbox_pkg::PARAM_RST;
      command_q  <= mailbox_pkg::COMMAND_RST;
    end else if (wr) begin
      if (req_q.addr == mailbox_pkg::THR_HIGH_ADDR) begin
        thr_high_q <= req_q.data;
      end
      if (req_q.addr == mailbox_pkg::PARAM_ADDR) begin
        param_q <= req_q.data;
      end
      if (cmd_wr) begin
        command_q <= req_q.data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Command issue and wake
  // ----------------------------------------------------------------------
  // A held error blocks every command except reset and no-op.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_valid_q <= 1'b0;
      cmd_code_q  <= mailbox_pkg::COMMAND_RST;
    end else begin
      cmd_valid_q <= cmd_wr && (!err_held || cmd_clear);
      if (cmd_wr) begin
        cmd_code_q <= req_q.data;
      end
    end
  end

  // Any other register access leaves the device asleep.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      awake_q <= 1'b0;
    end else if (cmd_wr) begin
      awake_q <= 1'b1;
    end else if (seq_sleep) begin
      awake_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Response register
  // ----------------------------------------------------------------------
  // Later assignments win: errors beat the clear made in the same cycle.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      response_q <= mailbox_pkg::RESPONSE_RST;
    end else begin
      if (wr && (req_q.addr == mailbox_pkg::RESPONSE_ADDR)) begin
        response_q <= req_q.data;
      end
      if (cmd_wr && cmd_clear) begin
        response_q <= mailbox_pkg::RESPONSE_RST;
      end else if (seq_done && !err_held) begin
        response_q <= {4'h0, response_q[3:0] + 4'h1};
      end
      if (seq_ovf_second) begin
        response_q <= mailbox_pkg::OVF_SECOND;
      end
      if (seq_invalid) begin
        response_q <= mailbox_pkg::INVALID_CODE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt flags and output
  // ----------------------------------------------------------------------
  logic [5:0] flag_set; // Hardware events this cycle.
  logic [5:0] flag_clr; // Host or sequencer clears this cycle.

  // Compare is not gated by the error state, so measuring goes on.
  assign flag_set = {seq_done,
                     prox3_valid && (prox3_result > {thr_high_q, thr_low}),
                     prox2_event, prox1_event, als_event};

  assign flag_clr =
    ((wr && !clear_policy && (req_q.addr == mailbox_pkg::FLAGS_ADDR)) ?
      req_q.data[5:0] : 6'h00) |
    ((clear_policy && seq_auto_clear) ? 6'h3f : 6'h00);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= mailbox_pkg::FLAGS_RST;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  // Active-low pin, registered so it never glitches.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_n_q <= 1'b1;
    end else begin
      int_n_q <= ~|(flags_q & irq_enable);
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence link_req_s;
    !reg_busy_q && (reg_we || reg_re);
  endsequence

  sequence link_ack_s;
    ##[4:16] reg_ack_q;
  endsequence

  link_answer_a: assert property (@(posedge link_clk)
    disable iff (!reset_n) link_req_s |-> link_ack_s)
    else $error("Register access never answered.");
  thr_compare_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    prox3_valid && (prox3_result > {thr_high_q, thr_low})
    |=> flags_q[mailbox_pkg::THIRD_BIT])
    else $error("Third threshold crossing not flagged.");
  err_code_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    seq_invalid |=> response_q == mailbox_pkg::INVALID_CODE)
    else $error("Invalid command code not loaded.");
  ovf_code_a: assert property (@(posedge core_clk)
    disable iff (!reset_n) seq_ovf_second && !seq_invalid
    |=> response_q == mailbox_pkg::OVF_SECOND && err_held)
    else $error("Overflow code not loaded.");
  err_hold_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    err_held && !(cmd_wr && cmd_clear) && !wr |=> err_held)
    else $error("Error code lost without clearing command.");
  cmd_ignore_a: assert property (@(posedge core_clk)
    disable iff (!reset_n) cmd_wr && err_held && !cmd_clear |=> !cmd_valid_q)
    else $error("Command issued while error held.");
  cmd_issue_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    cmd_wr && !err_held |=> cmd_valid_q && cmd_code_q == $past(req_q.data))
    else $error("Command not issued.");
  wake_only_a: assert property (@(posedge core_clk)
    disable iff (!reset_n) !awake_q && !cmd_wr |=> !awake_q)
    else $error("Woke without command write.");
  count_step_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    seq_done && !err_held && !wr && !seq_invalid && !seq_ovf_second
    |=> response_q[3:0] == $past(response_q[3:0]) + 4'h1
        && response_q[7:4] == 4'h0)
    else $error("Response counter did not advance.");
  irq_drive_a: assert property (@(posedge core_clk)
    disable iff (!reset_n) |(flags_q & irq_enable) |=> !int_n_q ##1 1'b1)
    else $error("Interrupt not driven.");
  auto_clear_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    clear_policy && seq_auto_clear && !prox3_valid && !seq_done
    && !prox1_event && !prox2_event && als_event == 2'b00
    |=> flags_q == 6'h00)
    else $error("Automatic clear left flags set.");

endmodule

//--- bench/host_port_model.sv
// Host side of the register port: issues one access at a time.
// Assumes the block answers each taken request with a one-cycle ack.
module host_port_model (
  input  wire logic       link_clk,
  input  wire logic       reg_busy_q,
  input  wire logic       reg_ack_q,
  input  wire logic [7:0] reg_rdata_q,
  output logic            reg_we,
  output logic            reg_re,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle port at time zero.
  initial begin
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One access. The strobe drops once busy shows the take, since a strobe
  // still high in the ack cycle would be taken a second time.
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
    @(posedge link_clk);
    reg_we <= w;
    reg_re <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    do @(posedge link_clk); while (reg_busy_q !== 1'b1);
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    // Completion is awaited, never assumed after a fixed delay.
    while (reg_ack_q !== 1'b1) @(posedge link_clk);
    // Released bus shows the inverse, not a stale copy.
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule

//--- bench/test_sensor_host_command_mailbox.sv
// Self-checking bench of the sensor command mailbox.
// Assumes the host model drives the link side; events are pulsed here.
`define CHK(n, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("mismatch %s exp %h got %h", n, e, g); \
  end \
end
module test_sensor_host_command_mailbox;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, link_clk, reset_n;     // Clocks and reset.
  logic        reg_we, reg_re, reg_ack_q, reg_busy_q;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_q;
  logic [7:0]  thr_low, cmd_code_q, param_q;
  logic [15:0] prox3_result;
  logic [9:0]  ev;            // Event pulses toward the block.
  logic        clear_policy, cmd_valid_q, awake_q, int_n_q;
  logic [5:0]  irq_enable;
  logic [31:0] seed;          // Random source state.
  logic [8:0]  exp_rd[$];     // Per access: check flag and read value.
  logic [7:0]  exp_cmd[$];    // Commands expected at the sequencer.
  logic [7:0]  map[6] = '{8'h16, 8'h17, 8'h18, 8'h20, 8'h21, 8'h30};
  int          fails = 0;
  int          check_count = 0;

  // ----------------------------------------------------------------------
  // Clocks, unrelated in phase
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #62.5 link_clk = ~link_clk;
  end

  sensor_host_command_mailbox u_sensor_host_command_mailbox (
    .core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk),
    .reg_we(reg_we), .reg_re(reg_re), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_ack_q(reg_ack_q), .reg_busy_q(reg_busy_q), .thr_low(thr_low),
    .prox3_valid(ev[9]), .prox3_result(prox3_result),
    .prox1_event(ev[5]), .prox2_event(ev[6]), .als_event(ev[8:7]),
    .seq_done(ev[0]), .seq_invalid(ev[1]), .seq_ovf_second(ev[2]),
    .seq_sleep(ev[3]), .seq_auto_clear(ev[4]),
    .clear_policy(clear_policy), .irq_enable(irq_enable),
    .cmd_valid_q(cmd_valid_q), .cmd_code_q(cmd_code_q),
    .param_q(param_q), .awake_q(awake_q), .int_n_q(int_n_q));

  host_port_model u_host_port_model (
    .link_clk(link_clk), .reg_busy_q(reg_busy_q), .reg_ack_q(reg_ack_q),
    .reg_rdata_q(reg_rdata_q), .reg_we(reg_we), .reg_re(reg_re),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  // ----------------------------------------------------------------------
  // Helpers and watchers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    exp_rd.push_back(9'h000);
    u_host_port_model.access(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_rd.push_back({1'b1, e});
    u_host_port_model.access(1'b0, a, 8'h00);
  endtask

  // One-cycle event pulse, then time for flags and interrupt to settle.
  task automatic fire(input logic [9:0] v);
    @(posedge core_clk);
    ev <= v;
    @(posedge core_clk);
    ev <= 10'h000;
    repeat (3) @(posedge core_clk);
  endtask

  // Every ack retires the oldest access note; reads compare their data.
  always @(posedge link_clk) begin
    if (reg_ack_q === 1'b1) begin
      if (exp_rd.size() == 0) begin
        `CHK("ack", 1'b0, reg_ack_q)
      end else if (exp_rd[0][8]) begin
        `CHK("rdata", exp_rd[0][7:0], reg_rdata_q)
      end
      if (exp_rd.size() != 0) void'(exp_rd.pop_front());
    end
  end

  // A command handed on without a note is an unexpected command.
  always @(posedge core_clk) begin
    if (cmd_valid_q === 1'b1) begin
      if (exp_cmd.size() == 0) begin
        `CHK("cmd_valid", 1'b0, cmd_valid_q)
      end else begin
        `CHK("cmd_code", exp_cmd.pop_front(), cmd_code_q)
      end
    end
  end

  // Notes still queued at the end mean a command or an answer never came.
  task automatic end_of_test();
    `CHK("cmd_left", 32'd0, exp_cmd.size())
    `CHK("access_left", 32'd0, exp_rd.size())
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A hang is cut short well past the expected run length.
  initial begin
    #400000;
    fails++;
    end_of_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    ev = 10'h000;
    thr_low = 8'h00;
    prox3_result = 16'h0000;
    clear_policy = 1'b0;
    irq_enable = 6'h00;
    seed = 32'hd8a09b6e;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge link_clk);
    `CHK("int_n", 1'b1, int_n_q)
    foreach (map[i]) rd(map[i], 8'h00);
    seed = lfsr(seed);
    wr(8'h17, seed[7:0]);
    rd(8'h17, seed[7:0]);
    `CHK("param", seed[7:0], param_q)
    `CHK("awake", 1'b0, awake_q)
    exp_cmd.push_back(8'h42);
    wr(8'h18, 8'h42);
    `CHK("awake", 1'b1, awake_q)
    rd(8'h18, 8'h42);
    fire(10'h008);
    `CHK("awake", 1'b0, awake_q)
    // Seventeen completions wrap the counter back to one.
    for (int i = 1; i <= 17; i++) begin
      fire(10'h001);
      if (i % 8 == 1) rd(8'h20, 8'(i % 16));
    end
    @(posedge core_clk);
    irq_enable <= 6'h20;
    repeat (3) @(posedge core_clk);
    `CHK("int_n", 1'b0, int_n_q)
    rd(8'h21, 8'h20);
    wr(8'h21, 8'h20);
    rd(8'h21, 8'h00);
    `CHK("int_n", 1'b1, int_n_q)
    wr(8'h20, 8'h05);
    rd(8'h20, 8'h05);
    // Error held: other commands ignored, measurements still flag.
    fire(10'h002);
    rd(8'h20, 8'h80);
    wr(8'h18, 8'h05);
    fire(10'h021);
    rd(8'h20, 8'h80);
    rd(8'h21, 8'h24);
    exp_cmd.push_back(8'h00);
    wr(8'h18, 8'h00);
    rd(8'h20, 8'h00);
    fire(10'h004);
    rd(8'h20, 8'h89);
    exp_cmd.push_back(8'h01);
    wr(8'h18, 8'h01);
    fire(10'h001);
    rd(8'h20, 8'h01);
    // Threshold written with no measurement pending; equal does not flag.
    seed = lfsr(seed);
    wr(8'h21, 8'h3f);
    wr(8'h16, {1'b0, seed[14:8]});
    @(posedge core_clk);
    thr_low <= seed[7:0];
    prox3_result <= {1'b0, seed[14:0]};
    fire(10'h200);
    rd(8'h21, 8'h00);
    @(posedge core_clk);
    prox3_result <= {1'b0, seed[14:0]} + 16'h0001;
    fire(10'h200);
    rd(8'h21, 8'h10);
    // Automatic clearing ignores host writes to the flags.
    @(posedge core_clk);
    clear_policy <= 1'b1;
    irq_enable <= 6'h3f;
    fire(10'h1e0);
    rd(8'h21, 8'h1f);
    `CHK("int_n", 1'b0, int_n_q)
    wr(8'h21, 8'h1f);
    rd(8'h21, 8'h1f);
    fire(10'h010);
    rd(8'h21, 8'h00);
    `CHK("int_n", 1'b1, int_n_q)
    repeat (4) @(posedge core_clk);
    end_of_test();
  end
endmodule
